// [hw/bsdr_sync.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes:   stage one feeds stage two only
module bsdr_sync #(
  parameter int W = 1
) (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic ce,
  bsdr_sync_if.sink sif
);
  logic [W-1:0] s1_r;     // metastable catch stage
  logic [W-1:0] s2_r;     // second stage
  logic [W-1:0] s3_r;     // third stage
  logic [W-1:0] clean_r;  // accepted level
  wire  [W-1:0] agree;    // stages two and three match

  assign agree = ~(s2_r ^ s3_r);

  // shift the chain; a change counts only once two stages agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_r    <= '0;
      s2_r    <= '0;
      s3_r    <= '0;
      clean_r <= '0;
    end else if (ce) begin
      s1_r    <= sif.raw;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      clean_r <= (agree & s3_r) | (~agree & clean_r);
    end
  end

  assign sif.clean = clean_r;
endmodule // bsdr_sync

// [hw/bsdr_top.sv]
// Purpose: boundary-scan data register with pin drive muxing
// Assumes: instruction decode outside gives extest_sel/sample_sel
//          levels on clk; tck, tms, tdi and pins are asynchronous
// Notes:   tck is oversampled by clk; its edges are found here
module bsdr_top #(
  parameter bit FULL_PINS = 1'b1  // 0 selects the reduced chain
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               ce,
  input  wire logic               extest_sel,
  input  wire logic               sample_sel,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo,
  output logic                    tdo_oe,
  input  wire logic               core_rst_oe,
  input  wire logic               core_weak_pullup_en,
  input  wire logic               core_can_rx_oe,
  input  wire logic               core_can_rx_out,
  input  wire logic               core_can_tx_oe,
  input  wire logic               core_can_tx_out,
  input  wire bsdr_pkg::bsdr_pins_t core_port_oe,
  input  wire bsdr_pkg::bsdr_pins_t core_port_out,
  input  wire logic               rst_pin_in,
  output logic                    rst_pin_oe,
  input  wire logic               can_rx_pin_in,
  output logic                    can_rx_pin_out,
  output logic                    can_rx_pin_oe,
  input  wire logic               can_tx_pin_in,
  output logic                    can_tx_pin_out,
  output logic                    can_tx_pin_oe,
  input  wire logic               crystal_input_pin,
  output logic                    weak_pullup_en,
  input  wire bsdr_pkg::bsdr_pins_t port_pin_in,
  output bsdr_pkg::bsdr_pins_t    port_pin_out,
  output bsdr_pkg::bsdr_pins_t    port_pin_oe
);
  import bsdr_pkg::*;

  // active chain length for the chosen variant
  localparam logic [6:0] LEN =
    FULL_PINS ? `BSDR_LEN_FULL : `BSDR_LEN_RED;  // RULE_01

  // synchronised copies of everything from outside clk
  bsdr_sync_if #(.W(`BSDR_SYNC_W)) sif ();

  // every outside level goes through the same three stages, so
  // tms and tdi stay aligned with the tck edge that samples them
  assign sif.raw = {port_pin_in,
                    crystal_input_pin,
                    can_tx_pin_in,
                    can_rx_pin_in,
                    rst_pin_in,
                    tdi,
                    tms,
                    tck};

  bsdr_sync #(.W(`BSDR_SYNC_W)) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .sif    (sif)
  );

  // named views of the clean lanes
  wire        tck_c;    // filtered test clock level
  wire        tms_c;    // filtered mode select
  wire        tdi_c;    // filtered scan input
  wire        rst_c;    // reset pin level
  wire        canrx_c;  // CAN receive pin level
  wire        cantx_c;  // CAN transmit pin level
  wire        xtal_c;   // crystal input level
  bsdr_pins_t port_c;   // port pin levels

  assign tck_c   = sif.clean[`BSDR_SY_TCK];
  assign tms_c   = sif.clean[`BSDR_SY_TMS];
  assign tdi_c   = sif.clean[`BSDR_SY_TDI];
  assign rst_c   = sif.clean[`BSDR_SY_RST];
  assign canrx_c = sif.clean[`BSDR_SY_CANRX];
  assign cantx_c = sif.clean[`BSDR_SY_CANTX];
  assign xtal_c  = sif.clean[`BSDR_SY_XTAL];
  assign port_c  = sif.clean[`BSDR_SY_PORT +: `BSDR_PIN_CNT];

  // state
  logic        tck_prev_r;  // tck level one clk ago
  bsdr_tap_t   tap_r;       // tap controller state
  bsdr_tap_t   tap_nxt;     // state after a rising tck
  bsdr_chain_t sr_r;        // shift stage of every cell
  bsdr_chain_t sr_nxt;      // shift stage after one shift
  bsdr_chain_t upd_r;       // update stage of every cell
  bsdr_chain_t cap_vec;     // values loaded in capture

  // edge detection on the filtered clock
  wire tck_rise;  // rising edge seen this clk
  wire tck_fall;  // falling edge seen this clk
  wire dr_sel;    // boundary register is the selected data reg
  wire do_cap;    // capture on this rising edge
  wire do_shift;  // shift on this rising edge
  wire do_upd;    // update on this falling edge

  assign tck_rise = tck_c & ~tck_prev_r;
  assign tck_fall = ~tck_c & tck_prev_r;

  // the tester must have loaded one of the two instructions;
  // otherwise the chain is left alone
  assign dr_sel   = extest_sel | sample_sel;  // RULE_17
  assign do_cap   = tck_rise & dr_sel & (tap_r == BSDR_CAP_DR);  // RULE_18
  assign do_shift = tck_rise & dr_sel & (tap_r == BSDR_SH_DR);  // RULE_18
  // sample never moves the update stage, so pins cannot glitch
  assign do_upd   = tck_fall & extest_sel
                  & (tap_r == BSDR_UPD_DR);  // RULE_02

  // standard tap transition on tms
  function automatic bsdr_tap_t tap_step(input bsdr_tap_t s,
                                         input logic      m);
    bsdr_tap_t n;
    n = s;
    unique case (s)
      BSDR_TLR:    n = m ? BSDR_TLR    : BSDR_RTI;
      BSDR_RTI:    n = m ? BSDR_SEL_DR : BSDR_RTI;
      BSDR_SEL_DR: n = m ? BSDR_SEL_IR : BSDR_CAP_DR;
      BSDR_CAP_DR: n = m ? BSDR_EX1_DR : BSDR_SH_DR;
      BSDR_SH_DR:  n = m ? BSDR_EX1_DR : BSDR_SH_DR;
      BSDR_EX1_DR: n = m ? BSDR_UPD_DR : BSDR_PAU_DR;
      BSDR_PAU_DR: n = m ? BSDR_EX2_DR : BSDR_PAU_DR;
      BSDR_EX2_DR: n = m ? BSDR_UPD_DR : BSDR_SH_DR;
      BSDR_UPD_DR: n = m ? BSDR_SEL_DR : BSDR_RTI;
      BSDR_SEL_IR: n = m ? BSDR_TLR    : BSDR_CAP_IR;
      BSDR_CAP_IR: n = m ? BSDR_EX1_IR : BSDR_SH_IR;
      BSDR_SH_IR:  n = m ? BSDR_EX1_IR : BSDR_SH_IR;
      BSDR_EX1_IR: n = m ? BSDR_UPD_IR : BSDR_PAU_IR;
      BSDR_PAU_IR: n = m ? BSDR_EX2_IR : BSDR_PAU_IR;
      BSDR_EX2_IR: n = m ? BSDR_UPD_IR : BSDR_SH_IR;
      BSDR_UPD_IR: n = m ? BSDR_SEL_DR : BSDR_RTI;
    endcase
    return n;
  endfunction

  assign tap_nxt = tap_step(tap_r, tms_c);

  // fixed cells below the port pins
  // cells 2 and 4 capture the enable really driven onto the pin
  assign cap_vec[`BSDR_CELL_RST_OE]   = core_rst_oe;  // RULE_03
  assign cap_vec[`BSDR_CELL_RST_IN]   = rst_c;  // RULE_04
  assign cap_vec[`BSDR_CELL_CANRX_OE] = can_rx_pin_oe;  // RULE_05
  assign cap_vec[`BSDR_CELL_CANRX_D]  = canrx_c;  // RULE_05
  assign cap_vec[`BSDR_CELL_CANTX_OE] = can_tx_pin_oe;  // RULE_06
  assign cap_vec[`BSDR_CELL_CANTX_D]  = cantx_c;  // RULE_06
  assign cap_vec[`BSDR_CELL_XTAL]     = xtal_c;  // RULE_07
  assign cap_vec[`BSDR_CELL_WPU]      = core_weak_pullup_en;  // RULE_08

  // port pins: one even/odd pair each, pins packed in order
  // port 0..3 in pins 0..31, port 4 pins 5-7 in 32..34,
  // ports 5..7 in 35..58, so cells follow 8+2k and 9+2k
  genvar k;
  generate
    for (k = 0; k < `BSDR_PIN_CNT; k++) begin : g_pin
      localparam int OE_CELL =
        `BSDR_CELL_PIN_BASE + `BSDR_CELLS_PER_PIN * k;
      localparam int D_CELL = OE_CELL + `BSDR_DAT_OFS;
      // even cell watches the core enable
      assign cap_vec[OE_CELL] = core_port_oe[k];  // RULE_09
      // odd cell watches the pin itself
      assign cap_vec[D_CELL] = port_c[k];  // RULE_09
    end
  endgenerate

  // shift path: tdi enters the last active cell, cell 0 leaves;
  // cells past a reduced chain simply hold
  genvar i;
  generate
    for (i = 0; i < `BSDR_LEN_FULL; i++) begin : g_shift
      if (i == LEN - 1) begin : g_head
        assign sr_nxt[i] = tdi_c;  // RULE_18
      end else if (i < LEN - 1) begin : g_body
        assign sr_nxt[i] = sr_r[i + 1];  // RULE_18
      end else begin : g_idle
        assign sr_nxt[i] = sr_r[i];  // RULE_01
      end
    end
  endgenerate

  // edge memory for tck
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tck_prev_r <= 1'b0;
    end else if (ce) begin
      tck_prev_r <= tck_c;
    end
  end

  // tap state advances on each rising tck
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tap_r <= BSDR_TLR;
    end else if (ce && tck_rise) begin
      tap_r <= tap_nxt;  // RULE_18
    end
  end

  // shift stage: capture wins over shift since both cannot
  // happen in one state anyway
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sr_r <= '0;
    end else if (ce && do_cap) begin
      sr_r <= cap_vec;  // RULE_02
    end else if (ce && do_shift) begin
      sr_r <= sr_nxt;  // RULE_18
    end
  end

  // update stage: loads only on the falling edge in update
  // state under EXTEST, otherwise holds its last value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upd_r <= '0;
    end else if (ce && do_upd) begin
      upd_r <= sr_r;  // RULE_02
    end
  end

  // scan output changes on falling tck, driven only in shift
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (ce && tck_fall) begin
      tdo    <= sr_r[`BSDR_CELL_RST_OE];  // RULE_18
      tdo_oe <= dr_sel & (tap_r == BSDR_SH_DR);  // RULE_18
    end
  end

  // pin drive selection: the update stage owns the pins only
  // while EXTEST is the live instruction
  bsdr_pins_t pin_oe_sel;   // chosen port enables
  bsdr_pins_t pin_out_sel;  // chosen port data
  wire        rst_oe_sel;   // chosen reset drive enable
  wire        wpu_sel;      // chosen pullup enable
  wire        rxoe_sel;     // chosen CAN rx enable
  wire        rxd_sel;      // chosen CAN rx data
  wire        txoe_sel;     // chosen CAN tx enable
  wire        txd_sel;      // chosen CAN tx data

  assign rst_oe_sel = extest_sel ? upd_r[`BSDR_CELL_RST_OE]
                                 : core_rst_oe;  // RULE_03
  assign wpu_sel    = extest_sel ? upd_r[`BSDR_CELL_WPU]
                                 : core_weak_pullup_en;  // RULE_08
  assign rxoe_sel   = extest_sel ? upd_r[`BSDR_CELL_CANRX_OE]
                                 : core_can_rx_oe;  // RULE_05
  assign rxd_sel    = extest_sel ? upd_r[`BSDR_CELL_CANRX_D]
                                 : core_can_rx_out;  // RULE_05
  assign txoe_sel   = extest_sel ? upd_r[`BSDR_CELL_CANTX_OE]
                                 : core_can_tx_oe;  // RULE_06
  assign txd_sel    = extest_sel ? upd_r[`BSDR_CELL_CANTX_D]
                                 : core_can_tx_out;  // RULE_06

  // port pin selection per pair
  // port 1..7 ranges fall out of the same packing:
  // 24-39, 40-55, 56-71, 72-77, 78-93, 94-109, 110-125
  generate
    for (k = 0; k < `BSDR_PIN_CNT; k++) begin : g_drv
      localparam int OE_CELL =
        `BSDR_CELL_PIN_BASE + `BSDR_CELLS_PER_PIN * k;
      localparam int D_CELL = OE_CELL + `BSDR_DAT_OFS;
      assign pin_oe_sel[k] = extest_sel ? upd_r[OE_CELL]
                                        : core_port_oe[k];  // RULE_10
      assign pin_out_sel[k] = extest_sel ? upd_r[D_CELL]
                                         : core_port_out[k];  // RULE_11
    end
  endgenerate
  // the packing above also places ports 3, 4, 5, 6 and 7
  // RULE_12 RULE_13 RULE_14 RULE_15 RULE_16

  // register every pin-side output so nothing combinational
  // reaches a pad; costs one clk of latency from the core
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_pin_oe     <= 1'b0;
      weak_pullup_en <= 1'b0;
      can_rx_pin_oe  <= 1'b0;
      can_rx_pin_out <= 1'b0;
      can_tx_pin_oe  <= 1'b0;
      can_tx_pin_out <= 1'b0;
      port_pin_oe    <= '0;
      port_pin_out   <= '0;
    end else if (ce) begin
      rst_pin_oe     <= rst_oe_sel;  // RULE_19
      weak_pullup_en <= wpu_sel;  // RULE_19
      can_rx_pin_oe  <= rxoe_sel;
      can_rx_pin_out <= rxd_sel;
      can_tx_pin_oe  <= txoe_sel;
      can_tx_pin_out <= txd_sel;
      port_pin_oe    <= pin_oe_sel;  // RULE_19
      port_pin_out   <= pin_out_sel;  // RULE_19
    end
  end
endmodule // bsdr_top

// [include/bsdr_map.svh]
// Purpose: named cell positions, lengths and sync lanes of the
//          boundary data register
// Assumes: included by bare name; definitions only
// Notes:   cell 0 sits next to the scan output
// Operation
// RULE_01: chain is 126 cells full, 118 reduced
// RULE_02: EXTEST captures and updates; SAMPLE only captures
// RULE_03: cell 0 captures/updates reset drive enable
// RULE_04: cell 1 captures reset pin, no update
// RULE_05: CAN receive pin uses cells 2 and 3
// RULE_06: CAN transmit pin uses cells 4 and 5
// RULE_07: cell 6 captures crystal input, no update
// RULE_08: cell 7 captures/updates global weak pullup enable
// RULE_09: port 0 pin n at cells 8+2n, 9+2n
// RULE_10: port 1 uses cells 24 to 39
// RULE_11: port 2 uses cells 40 to 55
// RULE_12: port 3 uses cells 56 to 71
// RULE_13: port 4 pins 5-7 use cells 72-77
// RULE_14: port 5 uses cells 78 to 93
// RULE_15: port 6 uses cells 94 to 109
// RULE_16: port 7 uses cells 110 to 125
// RULE_17: tester loads 16-bit EXTEST/SAMPLE instruction first
// RULE_18: shift TDI to TDO; standard TAP capture/update
// RULE_19: outside EXTEST core drives pins; latches hold
`ifndef BSDR_MAP_SVH
`define BSDR_MAP_SVH

`define BSDR_LEN_FULL      7'h7E
`define BSDR_LEN_RED       7'h76
`define BSDR_CELL_RST_OE   7'h00
`define BSDR_CELL_RST_IN   7'h01
`define BSDR_CELL_CANRX_OE 7'h02
`define BSDR_CELL_CANRX_D  7'h03
`define BSDR_CELL_CANTX_OE 7'h04
`define BSDR_CELL_CANTX_D  7'h05
`define BSDR_CELL_XTAL     7'h06
`define BSDR_CELL_WPU      7'h07
`define BSDR_CELL_PIN_BASE 7'h08
`define BSDR_CELLS_PER_PIN 7'h02
`define BSDR_DAT_OFS       7'h01
`define BSDR_PIN_CNT       7'h3B
`define BSDR_SYNC_W        7'h42
`define BSDR_SY_TCK        7'h00
`define BSDR_SY_TMS        7'h01
`define BSDR_SY_TDI        7'h02
`define BSDR_SY_RST        7'h03
`define BSDR_SY_CANRX      7'h04
`define BSDR_SY_CANTX      7'h05
`define BSDR_SY_XTAL       7'h06
`define BSDR_SY_PORT       7'h07

`endif

// [include/bsdr_pkg.sv]
// Purpose: types shared by the boundary data register modules
// Assumes: bsdr_map.svh supplies the widths
// Notes:   tap codes are gray along the data-register path
`include "bsdr_map.svh"
package bsdr_pkg;
  // one bit per scanned port pin, port 0 pin 0 in bit 0
  typedef logic [`BSDR_PIN_CNT-1:0] bsdr_pins_t;
  // full-length chain vector
  typedef logic [`BSDR_LEN_FULL-1:0] bsdr_chain_t;
  // tap controller states
  typedef enum logic [3:0] {
    BSDR_TLR     = 4'h0,
    BSDR_RTI     = 4'h1,
    BSDR_SEL_DR  = 4'h3,
    BSDR_CAP_DR  = 4'h2,
    BSDR_SH_DR   = 4'h6,
    BSDR_EX1_DR  = 4'h7,
    BSDR_UPD_DR  = 4'h5,
    BSDR_SEL_IR  = 4'h4,
    BSDR_CAP_IR  = 4'hC,
    BSDR_SH_IR   = 4'hD,
    BSDR_EX1_IR  = 4'hF,
    BSDR_PAU_DR  = 4'hE,
    BSDR_EX2_DR  = 4'hA,
    BSDR_PAU_IR  = 4'hB,
    BSDR_EX2_IR  = 4'h9,
    BSDR_UPD_IR  = 4'h8
  } bsdr_tap_t;
endpackage

// [include/bsdr_sync_if.sv]
// Purpose: carries raw outside levels and their synchronised copies
// Assumes: one clock domain on the clean side
// Notes:   width set by the instantiating module
interface bsdr_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;    // levels straight from pins
  logic [W-1:0] clean;  // filtered levels on clk
  modport src  (output raw, input clean);
  modport sink (input raw, output clean);
endinterface

// [testbench/bsdr_tester.sv]
// Purpose: behavioural scan tester driving tck, tms and tdi
// Assumes: the bench sets the instruction selects before a scan
// Notes:   tck stands low between frames; 125 ns period
module bsdr_tester (
  output logic      tck,  // scan clock, idle low
  output logic      tms,  // mode select
  output logic      tdi,  // scan data in
  input  wire logic tdo   // scan data out
);
  timeunit 1ns;
  timeprecision 100ps;
  // quiet link at start
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one tck period; tdo read just before the fall, long after it settled
  task automatic bit_cyc(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #62.5 tck = 1'b1;
    #62.0 o = tdo;
    #0.5 tck = 1'b0;
  endtask
  // five rises with tms high reach reset, then idle; tdi toggles when unused
  task automatic tap_reset();
    logic o;
    #1.3;
    repeat (5) bit_cyc(1'b1, ~tdi, o);
    bit_cyc(1'b0, ~tdi, o);
  endtask
  // one data register pass from idle back to idle, n bits shifted
  task automatic scan_dr(input logic [133:0] din, input int n,
                         output logic [133:0] dout);
    logic o;
    dout = '0;
    #1.3;
    bit_cyc(1'b1, ~tdi, o);  // select data path
    bit_cyc(1'b0, ~tdi, o);  // capture
    bit_cyc(1'b0, ~tdi, o);  // enter shift, capture lands here
    for (int i = 0; i < n; i++) begin
      bit_cyc(i == n - 1, din[i], dout[i]);
    end
    bit_cyc(1'b1, ~tdi, o);  // update on the following fall
    bit_cyc(1'b0, ~tdi, o);  // back to idle
  endtask
endmodule // bsdr_tester

// [testbench/bsdr_top_assertions.sv]
// Purpose: port-level checks on the boundary data register
// Assumes: one clk domain; tck is only oversampled by clk
// Notes:   timing windows allow for the tck synchroniser latency
module bsdr_top_assertions #(
  parameter bit FULL_PINS = 1'b1  // chain length select, handed on
) (
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 ce,
  input wire logic                 extest_sel,
  input wire logic                 tck,
  input wire logic                 tdo,
  input wire logic                 tdo_oe,
  input wire logic                 core_rst_oe,
  input wire logic                 core_weak_pullup_en,
  input wire bsdr_pkg::bsdr_pins_t core_port_oe,
  input wire bsdr_pkg::bsdr_pins_t core_port_out,
  input wire logic                 rst_pin_oe,
  input wire logic                 weak_pullup_en,
  input wire bsdr_pkg::bsdr_pins_t port_pin_out,
  input wire bsdr_pkg::bsdr_pins_t port_pin_oe
);
  import bsdr_pkg::*;
  logic [1:0] rcnt_r;    // edges since reset release, saturating
  logic [3:0] lo_cnt_r;  // edges with tck low, saturating
  // outputs checked against the core only from the third edge after release
  wire        run_ok = (rcnt_r == 2'h2) && ce;
  // core path settled and extest off at this edge
  wire        core_ok = run_ok && !extest_sel;

  // count edges since reset so early edges are skipped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rcnt_r <= 2'h0;
    else if (rcnt_r != 2'h2) rcnt_r <= rcnt_r + 2'h1;
  end
  // tck low time; tdo may only move a few edges after a fall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) lo_cnt_r <= 4'h0;
    else if (tck) lo_cnt_r <= 4'h0;
    else if (lo_cnt_r != 4'hF) lo_cnt_r <= lo_cnt_r + 4'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  follow_out_a: assert property (
    core_ok && $past(!extest_sel) |-> port_pin_out == $past(core_port_out))
    else $error("port output not from core");
  follow_oe_a: assert property (
    core_ok && $past(!extest_sel) |-> port_pin_oe == $past(core_port_oe))
    else $error("port enable not from core");
  rst_follow_a: assert property (
    core_ok && $past(!extest_sel) |-> rst_pin_oe == $past(core_rst_oe))
    else $error("reset enable not from core");
  wpu_follow_a: assert property (
    core_ok && $past(!extest_sel)
    |-> weak_pullup_en == $past(core_weak_pullup_en))
    else $error("pullup enable not from core");
  tdo_time_a: assert property (
    run_ok && $changed(tdo) |-> lo_cnt_r inside {[4'h3:4'h6]})
    else $error("scan out moved away from a tck fall");
  tdo_oe_time_a: assert property (
    run_ok && $changed(tdo_oe) |-> lo_cnt_r inside {[4'h3:4'h6]})
    else $error("scan out enable moved away from a tck fall");
  upd_time_a: assert property (
    run_ok && extest_sel && $past(extest_sel, 2) && $changed(port_pin_out)
    |-> lo_cnt_r inside {[4'h4:4'h9]})
    else $error("pin drive changed outside an update");
  reset_zero_a: assert property (
    $rose(resetn) |-> port_pin_out == '0 && port_pin_oe == '0 && !tdo_oe)
    else $error("outputs not cleared by reset");

  cover property (tdo_oe ##1 !tdo_oe);
  cover property (extest_sel && $changed(port_pin_out));
  cover property (!extest_sel && $changed(port_pin_out));
endmodule // bsdr_top_assertions

bind bsdr_top bsdr_top_assertions #(.FULL_PINS(FULL_PINS)) u_chk (
  .clk, .resetn, .ce, .extest_sel, .tck, .tdo, .tdo_oe, .core_rst_oe,
  .core_weak_pullup_en, .core_port_oe, .core_port_out, .rst_pin_oe,
  .weak_pullup_en, .port_pin_out, .port_pin_oe);

// [testbench/test_boundary_scan_data_register.sv]
// Purpose: self-checking bench for the boundary data register
// Assumes: random core and pin levels, fixed seed, tester partner
// Notes:   pins are held still around each capture for the syncs
module test_boundary_scan_data_register;
  import bsdr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk, resetn, extest_sel, sample_sel, tck, tms, tdi, tdo;
  logic         tdo_oe, core_rst_oe, core_weak_pullup_en, rst_pin_oe;
  logic         core_can_rx_oe, core_can_rx_out, core_can_tx_oe;
  logic         core_can_tx_out, rst_pin_in, can_rx_pin_in, can_tx_pin_in;
  logic         crystal_input_pin, can_rx_pin_out, can_rx_pin_oe;
  logic         can_tx_pin_out, can_tx_pin_oe, weak_pullup_en;
  bsdr_pins_t   core_port_oe, core_port_out, port_pin_in;
  bsdr_pins_t   port_pin_out, port_pin_oe;
  int           failures, n_compared, seed;
  logic [133:0] din, dout;        // scan in and scan out streams
  bsdr_chain_t  last_c;           // last vector loaded under extest

  bsdr_top u_dut (
    .clk, .resetn, .ce(1'b1), .extest_sel, .sample_sel, .tck, .tms, .tdi,
    .tdo, .tdo_oe, .core_rst_oe, .core_weak_pullup_en, .core_can_rx_oe,
    .core_can_rx_out, .core_can_tx_oe, .core_can_tx_out, .core_port_oe,
    .core_port_out, .rst_pin_in, .rst_pin_oe, .can_rx_pin_in,
    .can_rx_pin_out, .can_rx_pin_oe, .can_tx_pin_in, .can_tx_pin_out,
    .can_tx_pin_oe, .crystal_input_pin, .weak_pullup_en, .port_pin_in,
    .port_pin_out, .port_pin_oe);
  bsdr_tester u_tester (.tck, .tms, .tdi, .tdo);

  always #5 clk = ~clk;

  // expected capture vector; cells 2 and 4 see the enable really driven
  function automatic bsdr_chain_t exp_cap(logic rxoe, logic txoe);
    bsdr_chain_t v;
    v = '0;
    v[0] = core_rst_oe;
    v[1] = rst_pin_in;
    v[2] = rxoe;
    v[3] = can_rx_pin_in;
    v[4] = txoe;
    v[5] = can_tx_pin_in;
    v[6] = crystal_input_pin;
    v[7] = core_weak_pullup_en;
    for (int k = 0; k < 59; k++) begin
      v[8 + 2 * k] = core_port_oe[k];
      v[9 + 2 * k] = port_pin_in[k];
    end
    return v;
  endfunction
  // vector compare, values zero-extended by the caller
  task automatic chk_vec(input logic [133:0] got, input logic [133:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // single-bit compare
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // new random core and pin levels, called at a falling edge
  task automatic rand_inputs();
    logic [63:0] a, b, c;
    logic [31:0] r;
    a = {$urandom(), $urandom()};
    b = {$urandom(), $urandom()};
    c = {$urandom(), $urandom()};
    r = $urandom();
    core_port_oe = a[58:0];
    core_port_out = b[58:0];
    port_pin_in = c[58:0];
    {core_rst_oe, core_weak_pullup_en, core_can_rx_oe, core_can_rx_out,
     core_can_tx_oe, core_can_tx_out, rst_pin_in, can_rx_pin_in,
     can_tx_pin_in, crystal_input_pin} = r[9:0];
  endtask
  // pins driven straight from the core
  task automatic check_core();
    repeat (3) @(negedge clk);
    chk_vec(134'(port_pin_out), 134'(core_port_out));
    chk_vec(134'(port_pin_oe), 134'(core_port_oe));
    chk_bit(can_tx_pin_out, core_can_tx_out);
    chk_bit(can_tx_pin_oe, core_can_tx_oe);
    chk_bit(can_rx_pin_out, core_can_rx_out);
    chk_bit(can_rx_pin_oe, core_can_rx_oe);
    chk_bit(rst_pin_oe, core_rst_oe);
    chk_bit(weak_pullup_en, core_weak_pullup_en);
  endtask
  // pins driven from an update vector
  task automatic check_upd(input bsdr_chain_t c);
    bsdr_pins_t oe, d;
    for (int k = 0; k < 59; k++) begin
      oe[k] = c[8 + 2 * k];
      d[k] = c[9 + 2 * k];
    end
    chk_bit(rst_pin_oe, c[0]);
    chk_bit(can_rx_pin_oe, c[2]);
    chk_bit(can_rx_pin_out, c[3]);
    chk_bit(can_tx_pin_oe, c[4]);
    chk_bit(can_tx_pin_out, c[5]);
    chk_bit(weak_pullup_en, c[7]);
    chk_vec(134'(port_pin_oe), 134'(oe));
    chk_vec(134'(port_pin_out), 134'(d));
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #500000;
    failures++;
    end_of_test();
  end

  // main sequence
  initial begin
    seed = $urandom(80);
    {clk, resetn, extest_sel, sample_sel} = 4'h0;
    din = '0;
    rand_inputs();
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (20) begin
      rand_inputs();
      check_core();
    end
    // extest: all ones, all zeros, then random loads
    extest_sel = 1'b1;
    u_tester.tap_reset();
    for (int t = 0; t < 4; t++) begin
      last_c = din[125:0];
      din = (t == 0) ? '1 : '0;
      if (t > 1) for (int i = 0; i < 134; i++) din[i] = 1'($urandom() & 1);
      @(negedge clk);
      rand_inputs();
      repeat (10) @(negedge clk);
      u_tester.scan_dr(din, 126, dout);
      repeat (10) @(negedge clk);
      check_upd(din[125:0]);
      chk_vec(dout, 134'(exp_cap(last_c[2], last_c[4])));
    end
    last_c = din[125:0];
    // extest off: core owns the pins again
    extest_sel = 1'b0;
    repeat (5) begin
      rand_inputs();
      check_core();
    end
    // sample: capture only, a stream longer than the chain
    sample_sel = 1'b1;
    for (int i = 0; i < 134; i++) din[i] = 1'($urandom() & 1);
    repeat (10) @(negedge clk);
    u_tester.scan_dr(din, 134, dout);
    chk_vec(134'(dout[125:0]), 134'(exp_cap(core_can_rx_oe, core_can_tx_oe)));
    chk_vec(134'(dout[133:126]), 134'(din[7:0]));
    check_core();
    // back in extest with no scan: the latches kept the last load
    sample_sel = 1'b0;
    extest_sel = 1'b1;
    repeat (3) @(negedge clk);
    check_upd(last_c);
    end_of_test();
  end
endmodule // test_boundary_scan_data_register
